// ---- valve_policy_consts.vh ----
// constants for the valve output fault policy block
// assumes a 50 MHz clock and a 32-bit avalon-mm slave with byte addresses
`ifndef VALVE_POLICY_CONSTS_VH
`define VALVE_POLICY_CONSTS_VH

`define NCH              8
`define CLK_HZ           64'd50000000
`define HOUR_S           64'd3600
`define HOUR_CYCLES      (`HOUR_S * `CLK_HZ)
`define LIMIT_SCALE      32'd1000

// register byte offsets
`define REG_CTRL         8'h00
`define REG_OUT_CMD      8'h04
`define REG_FAULT_ACT    8'h08
`define REG_IDLE_ACT     8'h0C
`define REG_CNT_EN       8'h10
`define REG_STATUS       8'h14
`define REG_CNT_CLEAR    8'h18
`define REG_CNT_SEL      8'h1C
`define REG_THRESH       8'h20
`define REG_COUNT        8'h24
`define REG_OUTPUTS      8'h28

// control bits
`define CTRL_PRIO_SW     0
`define CTRL_CTL_MON     1
`define CTRL_OUT_MON     2
`define CTRL_SC_EN       3
`define CTRL_SC_MANUAL   4
`define CTRL_W           5
`define CTRL_RESET       5'h0A

// status fields
`define ST_CTL_LOW       0
`define ST_OUT_LOW       1
`define ST_SC_LSB        8
`define ST_CNT_LSB       16

// per-channel action codes
`define ACT_CLEAR        2'h0
`define ACT_HOLD         2'h1
`define ACT_FORCE_ON     2'h2

`define THRESH_RESET     16'h0001
`define THRESH_MAX       16'hFDE8

`endif

// ---- valve_policy.v ----
// valve output fault policy, supply monitors, short latch and operation counters
// assumes pins arrive asynchronously; retained storage answers on nv_* in this clock domain
// Summary of operation
// RULE1: priority bit selects switch-driven or parameter-driven fault outputs; switch is default
// RULE2: per-channel fault and idle actions clear, hold or force on, only in software priority
// RULE3: enabled supply monitors flag control supply under 18 V, output supply under 19 V
// RULE4: enabled short detection flags shorted valve outputs; disabled gives no error
// RULE5: automatic restart clears the short error once the short disappears
// RULE6: manual restart keeps the short error latched until power is applied again
// RULE7: enabled channel counter check flags count above threshold, threshold 1 to 65000
// RULE8: effective limit is the threshold times one thousand
// RULE9: counts saved hourly to retained storage and reloaded after power-up
// RULE10: counter-clear command sets that channel count to zero; a clear in the cycle of an on-to-off edge leaves it at one
// RULE11: each full off-on-off cycle of a valve output adds one to its count; a count at its 32-bit maximum stays there
// RULE12: in software priority without fault or idle, outputs follow controller commands
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "valve_policy_consts.vh"

module valve_policy
#(
    parameter [63:0] HOUR_CYCLES = `HOUR_CYCLES
)
(
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire [7:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    input  wire        comm_fault_i,
    input  wire        comm_idle_i,
    input  wire        switch_hold_i,
    input  wire        ctl_supply_low_i,
    input  wire        out_supply_low_i,
    input  wire [7:0]  short_det_i,
    input  wire        nv_load_i,
    input  wire [2:0]  nv_load_idx_i,
    input  wire [31:0] nv_load_data_i,
    output reg  [7:0]  valve_o,
    output reg         ctl_supply_err_o,
    output reg         out_supply_err_o,
    output reg  [7:0]  short_err_o,
    output reg  [7:0]  cnt_err_o,
    output reg         nv_wr_o,
    output reg  [2:0]  nv_idx_o,
    output reg  [31:0] nv_data_o
);

    function [31:0] merge_be;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                merge_be[k*8 +: 8] = be[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
        end
    endfunction

    function [31:0] op_limit;
        input [15:0] thr;
        begin
            op_limit = {16'h0000, thr} * `LIMIT_SCALE;
        end
    endfunction

    function [1:0] pick_action;
        input [15:0] acts;
        input [2:0]  ch;
        begin
            pick_action = acts[ch*2 +: 2];
        end
    endfunction

    // pin synchronisers
    reg  [12:0] sync_a;
    reg  [12:0] sync_b;
    wire        fault_s = sync_b[0];
    wire        idle_s  = sync_b[1];
    wire        sw_hold = sync_b[2];
    wire        ctl_low = sync_b[3];
    wire        out_low = sync_b[4];
    wire [7:0]  short_s = sync_b[12:5];

    reg  [`CTRL_W-1:0] ctrl;
    reg  [7:0]         out_cmd;
    reg  [15:0]        fault_act;
    reg  [15:0]        idle_act;
    reg  [7:0]         cnt_en;
    reg  [2:0]         cnt_sel;
    reg  [15:0]        thresh [0:`NCH-1];
    reg  [31:0]        count  [0:`NCH-1];
    reg                ack;
    reg  [63:0]        hour_cnt;
    reg                save_busy;
    reg  [2:0]         save_idx;

    reg  [7:0]  next_valve;
    reg  [7:0]  next_short;
    reg  [7:0]  next_cnt_err;
    reg  [7:0]  clr_req;
    reg  [31:0] rd_mux;
    reg  [31:0] status_w;
    integer     i;
    // one loop index per process, so each index has a single writer
    integer     j;
    integer     n;

    wire req      = avs_read_i | avs_write_i;
    wire wr_go    = avs_write_i & ack;
    wire hour_tick = (hour_cnt == HOUR_CYCLES - 64'd1);

    assign avs_waitrequest_o = req & ~ack;

    // byte-lane merged write values, cut back to register width where used
    wire [31:0] ctrl_wr  = merge_be({27'h0, ctrl}, avs_writedata_i, avs_byteenable_i);
    wire [31:0] fault_wr = merge_be({16'h0, fault_act}, avs_writedata_i, avs_byteenable_i);
    wire [31:0] idle_wr  = merge_be({16'h0, idle_act}, avs_writedata_i, avs_byteenable_i);

    // output policy per channel
    always @*
    begin
        for (i = 0; i < `NCH; i = i + 1)
        begin
            // RULE12: follow the controller
            next_valve[i] = out_cmd[i];
            if (!ctrl[`CTRL_PRIO_SW])
            begin
                // RULE1: switch selects off or hold for all
                if (fault_s || idle_s)
                    next_valve[i] = sw_hold ? valve_o[i] : 1'b0;
            end
            else if (fault_s || idle_s)
            begin
                // RULE2: per-channel fault or idle action
                case (fault_s ? pick_action(fault_act, i[2:0]) : pick_action(idle_act, i[2:0]))
                    `ACT_CLEAR:    next_valve[i] = 1'b0;
                    `ACT_HOLD:     next_valve[i] = valve_o[i];
                    `ACT_FORCE_ON: next_valve[i] = 1'b1;
                    default:       next_valve[i] = 1'b0;
                endcase
            end
        end
    end

    // short error and counter limit flags
    always @*
    begin
        for (j = 0; j < `NCH; j = j + 1)
        begin
            // RULE4: no error while detection is off
            if (!ctrl[`CTRL_SC_EN])
                next_short[j] = 1'b0;
            else if (short_s[j])
                next_short[j] = 1'b1;
            // RULE5: auto restart drops the error
            else if (!ctrl[`CTRL_SC_MANUAL])
                next_short[j] = 1'b0;
            // RULE6: manual restart holds until reset
            else
                next_short[j] = short_err_o[j];
            // RULE7: count above limit while enabled
            // RULE8: limit is threshold times one thousand
            next_cnt_err[j] = cnt_en[j] && (count[j] > op_limit(thresh[j]));
        end
    end

    always @*
    begin
        status_w = 32'h0000_0000;
        status_w[`ST_CTL_LOW] = ctl_supply_err_o;
        status_w[`ST_OUT_LOW] = out_supply_err_o;
        status_w[`ST_SC_LSB +: 8] = short_err_o;
        status_w[`ST_CNT_LSB +: 8] = cnt_err_o;
        clr_req = (wr_go && avs_address_i == `REG_CNT_CLEAR && avs_byteenable_i[0]) ?
                  avs_writedata_i[7:0] : 8'h00;
        case (avs_address_i)
            `REG_CTRL:      rd_mux = {27'h0, ctrl};
            `REG_OUT_CMD:   rd_mux = {24'h0, out_cmd};
            `REG_FAULT_ACT: rd_mux = {16'h0, fault_act};
            `REG_IDLE_ACT:  rd_mux = {16'h0, idle_act};
            `REG_CNT_EN:    rd_mux = {24'h0, cnt_en};
            `REG_STATUS:    rd_mux = status_w;
            `REG_CNT_SEL:   rd_mux = {29'h0, cnt_sel};
            `REG_THRESH:    rd_mux = {16'h0, thresh[cnt_sel]};
            `REG_COUNT:     rd_mux = count[cnt_sel];
            `REG_OUTPUTS:   rd_mux = {24'h0, valve_o};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            sync_a           <= 13'h0000;
            sync_b           <= 13'h0000;
            ack              <= 1'b0;
            avs_readdata_o   <= 32'h0000_0000;
            ctrl             <= `CTRL_RESET;
            out_cmd          <= 8'h00;
            fault_act        <= 16'h0000;
            idle_act         <= 16'h0000;
            cnt_en           <= 8'h00;
            cnt_sel          <= 3'h0;
            valve_o          <= 8'h00;
            ctl_supply_err_o <= 1'b0;
            out_supply_err_o <= 1'b0;
            short_err_o      <= 8'h00;
            cnt_err_o        <= 8'h00;
            hour_cnt         <= 64'h0;
            save_busy        <= 1'b0;
            save_idx         <= 3'h0;
            nv_wr_o          <= 1'b0;
            nv_idx_o         <= 3'h0;
            nv_data_o        <= 32'h0000_0000;
            for (n = 0; n < `NCH; n = n + 1)
            begin
                thresh[n] <= `THRESH_RESET;
                count[n]  <= 32'h0000_0000;
            end
        end
        else if (ce_i)
        begin
            sync_a <= {short_det_i, out_supply_low_i, ctl_supply_low_i,
                       switch_hold_i, comm_idle_i, comm_fault_i};
            sync_b <= sync_a;

            // bus slave: one wait cycle, then answer
            ack <= req & ~ack;
            if (req && !ack)
                avs_readdata_o <= avs_read_i ? rd_mux : 32'h0000_0000;
            if (wr_go)
            begin
                case (avs_address_i)
                    `REG_CTRL:
                        ctrl <= ctrl_wr[`CTRL_W-1:0];
                    `REG_OUT_CMD:
                        out_cmd <= avs_byteenable_i[0] ? avs_writedata_i[7:0] : out_cmd;
                    `REG_FAULT_ACT:
                        fault_act <= fault_wr[15:0];
                    `REG_IDLE_ACT:
                        idle_act <= idle_wr[15:0];
                    `REG_CNT_EN:
                        cnt_en <= avs_byteenable_i[0] ? avs_writedata_i[7:0] : cnt_en;
                    `REG_CNT_SEL:
                        cnt_sel <= avs_byteenable_i[0] ? avs_writedata_i[2:0] : cnt_sel;
                    `REG_THRESH:
                        // out-of-range thresholds are ignored
                        if (avs_byteenable_i[1:0] == 2'b11 && avs_writedata_i[15:0] != 16'h0000 &&
                            avs_writedata_i[15:0] <= `THRESH_MAX)
                            thresh[cnt_sel] <= avs_writedata_i[15:0];
                    default:
                        ctrl <= ctrl;
                endcase
            end

            valve_o <= next_valve;
            // RULE3: supply monitors gated by their enables
            ctl_supply_err_o <= ctrl[`CTRL_CTL_MON] & ctl_low;
            out_supply_err_o <= ctrl[`CTRL_OUT_MON] & out_low;
            short_err_o      <= next_short;
            cnt_err_o        <= next_cnt_err;

            for (n = 0; n < `NCH; n = n + 1)
            begin
                // RULE10: clear command zeroes the count, or sets it to one when an on-to-off edge falls in the same cycle
                if (clr_req[n])
                    count[n] <= {31'h0, valve_o[n] & ~next_valve[n]};
                // RULE9: reload the saved value after power-up
                else if (nv_load_i && nv_load_idx_i == n[2:0])
                    count[n] <= nv_load_data_i;
                // RULE11: count on the on-to-off edge
                else if (valve_o[n] && !next_valve[n] && count[n] != 32'hFFFF_FFFF)
                    count[n] <= count[n] + 32'h0000_0001;
            end

            // RULE9: hourly walk writing every count out
            hour_cnt <= hour_tick ? 64'h0 : hour_cnt + 64'h1;
            nv_wr_o  <= save_busy;
            if (save_busy)
            begin
                nv_idx_o  <= save_idx;
                nv_data_o <= count[save_idx];
                save_idx  <= save_idx + 3'h1;
                if (save_idx == 3'h7)
                    save_busy <= 1'b0;
            end
            else if (hour_tick)
            begin
                save_busy <= 1'b1;
                save_idx  <= 3'h0;
            end
        end
    end

endmodule

// ---- valve_policy_asserts.sv ----
// port checker for valve_policy
// assumes ce_i held high; bound from the bench top
`timescale 1ns/1ps
module valve_policy_asserts
(
    input wire       ref_clk_i,
    input wire       rst_i,
    input wire       avs_read_i,
    input wire       avs_write_i,
    input wire       avs_waitrequest_o,
    input wire       ctl_supply_low_i,
    input wire       out_supply_low_i,
    input wire [7:0] short_det_i,
    input wire       ctl_supply_err_o,
    input wire       out_supply_err_o,
    input wire [7:0] short_err_o,
    input wire       nv_wr_o,
    input wire [2:0] nv_idx_o
);
default clocking cb @(posedge ref_clk_i);
endclocking
default disable iff (rst_i);
wire req = avs_read_i | avs_write_i;
sequence burst_s;
    nv_wr_o [*8] ##1 !nv_wr_o;
endsequence
wait_one_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
wait_idle_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait without request");
ctl_err_src_a: assert property ($rose(ctl_supply_err_o) |-> $past(ctl_supply_low_i, 3))
    else $error("control supply error without cause");
out_err_src_a: assert property ($rose(out_supply_err_o) |-> $past(out_supply_low_i, 3))
    else $error("output supply error without cause");
short_src_a: assert property ((short_err_o & ~$past(short_err_o) & ~$past(short_det_i, 3)) == 8'h00)
    else $error("short error without short");
burst_len_a: assert property ($rose(nv_wr_o) |-> burst_s)
    else $error("save burst not eight slots");
burst_start_a: assert property ($rose(nv_wr_o) |-> nv_idx_o == 3'h0)
    else $error("save burst not from slot zero");
burst_order_a: assert property (nv_wr_o && $past(nv_wr_o) |-> nv_idx_o == $past(nv_idx_o) + 3'h1)
    else $error("save slots out of order");
endmodule

// ---- nv_store_model.sv ----
// retained count storage behind the nv pins
// assumes the block clock; restore_i starts an eight-slot reload
`timescale 1ns/1ps
module nv_store_model
(
    input  wire        clk_i,
    input  wire        nv_wr_i,
    input  wire [2:0]  nv_idx_i,
    input  wire [31:0] nv_data_i,
    input  wire        restore_i,
    output reg         load_o,
    output reg  [2:0]  load_idx_o,
    output reg  [31:0] load_data_o
);
reg [31:0] mem [0:7];
reg [3:0]  left = 4'h0;
initial
begin
    load_o = 1'b0;
    load_idx_o = 3'h0;
    load_data_o = 32'h0;
end
always @(posedge clk_i)
begin
    if (nv_wr_i)
        mem[nv_idx_i] <= nv_data_i;
    if (restore_i)
        left <= 4'h8;
    else if (left != 4'h0)
        left <= left - 4'h1;
    load_o <= (left != 4'h0);
    load_idx_o <= 3'h0 - left[2:0];
    load_data_o <= (left != 4'h0) ? mem[3'h0 - left[2:0]] : ~load_data_o;
end
endmodule

// ---- valve_policy_tb_top.sv ----
// self-checking bench for valve_policy with the storage model
// assumes 50 MHz clock; hour shortened to 400 cycles
`timescale 1ns/1ps
`include "valve_policy_consts.vh"
module valve_policy_tb_top;
reg         ref_clk_i = 1'b0;
reg         rst_i = 1'b1;
reg         avs_read_i = 1'b0;
reg         avs_write_i = 1'b0;
reg  [7:0]  avs_address_i = 8'h00;
reg  [31:0] avs_writedata_i = 32'h0;
reg         comm_fault_i = 1'b0;
reg         comm_idle_i = 1'b0;
reg         switch_hold_i = 1'b0;
reg         ctl_supply_low_i = 1'b0;
reg         out_supply_low_i = 1'b0;
reg  [7:0]  short_det_i = 8'h00;
reg         restore = 1'b0;
wire [31:0] avs_readdata_o, nv_load_data_i, nv_data_o;
wire        avs_waitrequest_o, nv_load_i, ctl_supply_err_o, out_supply_err_o, nv_wr_o;
wire [7:0]  valve_o, short_err_o, cnt_err_o;
wire [2:0]  nv_load_idx_i, nv_idx_o;
reg  [31:0] rv;
integer     error_cnt = 0;
integer     checks = 0;
integer     cyc = 0;
always #10 ref_clk_i = ~ref_clk_i;
valve_policy #(.HOUR_CYCLES(64'd400)) uut (.ref_clk_i, .rst_i, .ce_i(1'b1), .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .comm_fault_i,
    .comm_idle_i, .switch_hold_i, .ctl_supply_low_i, .out_supply_low_i, .short_det_i, .nv_load_i,
    .nv_load_idx_i, .nv_load_data_i, .valve_o, .ctl_supply_err_o, .out_supply_err_o, .short_err_o,
    .cnt_err_o, .nv_wr_o, .nv_idx_o, .nv_data_o);
nv_store_model p (.clk_i(ref_clk_i), .nv_wr_i(nv_wr_o), .nv_idx_i(nv_idx_o), .nv_data_i(nv_data_o),
    .restore_i(restore), .load_o(nv_load_i), .load_idx_o(nv_load_idx_i), .load_data_o(nv_load_data_i));
task results;
begin
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
always @(posedge ref_clk_i)
begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
        error_cnt = error_cnt + 1;
        results;
    end
end
task tick(input integer n);
    repeat (n) @(posedge ref_clk_i);
endtask
task chk(input [31:0] got, input [31:0] exp);
begin
    checks = checks + 1;
    if (got !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
end
endtask
task bus(input w, input [7:0] a, input [31:0] d);
begin
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0)
        @(posedge ref_clk_i);
    rv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
end
endtask
task toggle;
begin
    bus(1'b1, `REG_OUT_CMD, 32'h1);
    bus(1'b1, `REG_OUT_CMD, 32'h0);
end
endtask
task burst;
begin
    while (nv_wr_o === 1'b1) tick(1);
    while (nv_wr_o !== 1'b1) tick(1);
    while (nv_wr_o === 1'b1) tick(1);
end
endtask
task t_switch;
begin
    bus(1'b0, `REG_CTRL, 32'h0); chk(rv, 32'h0A);
    bus(1'b0, 8'h40, 32'h0); chk(rv, 32'h0);
    bus(1'b1, `REG_OUT_CMD, 32'hA5);
    comm_fault_i <= 1'b1;
    switch_hold_i <= 1'b1;
    tick(4); chk({24'h0, valve_o}, 32'hA5);
    switch_hold_i <= 1'b0;
    tick(4); chk({24'h0, valve_o}, 32'h00);
    comm_fault_i <= 1'b0;
    $display("switch test done");
end
endtask
task t_soft;
begin
    // fault codes per channel 0,1,2,0,1,2,0,1; idle codes 2,1,0,2,1,0,2,1
    bus(1'b1, `REG_CTRL, 32'h0B);
    bus(1'b1, `REG_FAULT_ACT, 32'h4924);
    bus(1'b1, `REG_IDLE_ACT, 32'h6186);
    tick(4); chk({24'h0, valve_o}, 32'hA5);
    comm_fault_i <= 1'b1;
    tick(4); chk({24'h0, valve_o}, 32'hA4);
    comm_fault_i <= 1'b0;
    tick(4);
    comm_idle_i <= 1'b1;
    tick(4); chk({24'h0, valve_o}, 32'hC9);
    // fault on top of idle: fault actions win, hold keeps the idle result
    comm_fault_i <= 1'b1;
    tick(4); chk({24'h0, valve_o}, 32'hA4);
    bus(1'b0, `REG_OUTPUTS, 32'h0); chk(rv, 32'hA4);
    comm_fault_i <= 1'b0;
    comm_idle_i <= 1'b0;
    $display("software policy test done");
end
endtask
task t_supply;
begin
    ctl_supply_low_i <= 1'b1;
    out_supply_low_i <= 1'b1;
    tick(4); chk({ctl_supply_err_o, out_supply_err_o}, 32'h2);
    bus(1'b1, `REG_CTRL, 32'h0F);
    tick(4); chk({ctl_supply_err_o, out_supply_err_o}, 32'h3);
    bus(1'b0, `REG_STATUS, 32'h0); chk(rv & 32'h3, 32'h3);
    ctl_supply_low_i <= 1'b0;
    out_supply_low_i <= 1'b0;
    tick(4); chk({ctl_supply_err_o, out_supply_err_o}, 32'h0);
    $display("supply test done");
end
endtask
task t_short;
begin
    bus(1'b1, `REG_CTRL, 32'h07);
    short_det_i <= 8'h03;
    tick(4); chk({24'h0, short_err_o}, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h0F);
    tick(4); chk({24'h0, short_err_o}, 32'h3);
    short_det_i <= 8'h00;
    tick(4); chk({24'h0, short_err_o}, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h1F);
    short_det_i <= 8'h03;
    tick(4);
    short_det_i <= 8'h00;
    tick(4); chk({24'h0, short_err_o}, 32'h3);
    bus(1'b0, `REG_STATUS, 32'h0); chk(rv, 32'h0000_0300);
    $display("short test done");
end
endtask
task t_count;
begin
    bus(1'b1, `REG_OUT_CMD, 32'h0);
    tick(4);
    bus(1'b1, `REG_CNT_CLEAR, 32'h1);
    bus(1'b1, `REG_CNT_EN, 32'h1);
    repeat (1000) toggle;
    tick(4);
    bus(1'b0, `REG_COUNT, 32'h0); chk(rv, 32'd1000);
    chk({24'h0, cnt_err_o}, 32'h0);
    toggle;
    tick(4); chk({24'h0, cnt_err_o}, 32'h1);
    bus(1'b1, `REG_CNT_CLEAR, 32'h1);
    tick(4);
    bus(1'b0, `REG_COUNT, 32'h0); chk(rv, 32'h0);
    chk({24'h0, cnt_err_o}, 32'h0);
    bus(1'b1, `REG_THRESH, 32'hFDE9);
    bus(1'b0, `REG_THRESH, 32'h0); chk(rv, 32'h1);
    bus(1'b1, `REG_THRESH, 32'hFDE8);
    bus(1'b0, `REG_THRESH, 32'h0); chk(rv, 32'hFDE8);
    $display("counter test done");
end
endtask
task t_save;
begin
    toggle;
    tick(4);
    burst;
    rst_i <= 1'b1;
    tick(4);
    rst_i <= 1'b0;
    tick(4); chk({24'h0, short_err_o}, 32'h0);
    restore <= 1'b1;
    tick(1);
    restore <= 1'b0;
    tick(12);
    bus(1'b0, `REG_COUNT, 32'h0); chk(rv, 32'h1);
    $display("save test done");
end
endtask
initial
begin
    tick(4);
    rst_i <= 1'b0;
    t_switch;
    t_soft;
    t_supply;
    t_short;
    t_count;
    t_save;
    results;
end
endmodule
bind valve_policy valve_policy_asserts prop (.ref_clk_i, .rst_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .ctl_supply_low_i, .out_supply_low_i, .short_det_i, .ctl_supply_err_o,
    .out_supply_err_o, .short_err_o, .nv_wr_o, .nv_idx_o);
